// ==== verilog/xlat_pkg.sv ====
// constants for the paged address translation unit
// assumes a single clock domain and a plain register port
package xlat_pkg;
  localparam int PAGES      = 64;
  localparam int IDX_W      = 6;
  localparam int SEG_W      = 7;
  localparam int OFF_W      = 16;
  localparam int LADDR_W    = 23;
  localparam int PAGE_OFF_W = 11;
  localparam int LPN_W      = 12;
  localparam int FRAME_W    = 13;
  localparam int PADDR_W    = 24;
  localparam int WARN_LSB   = 7;
  localparam int ADDR_W     = 6;
  localparam int DATA_W     = 32;

  localparam logic [5:0] REG_MODE   = 6'h00;
  localparam logic [5:0] REG_SEL    = 6'h04;
  localparam logic [5:0] REG_TAG    = 6'h08;
  localparam logic [5:0] REG_FRAME  = 6'h0C;
  localparam logic [5:0] REG_ATTR   = 6'h10;
  localparam logic [5:0] REG_STAT   = 6'h14;
  localparam logic [5:0] REG_MASK   = 6'h18;
  localparam logic [5:0] REG_FADDR  = 6'h1C;
  localparam logic [5:0] REG_FINFO  = 6'h20;

  localparam int MODE_W    = 3;
  localparam int MODE_XLAT = 0;
  localparam int MODE_NORM = 1;
  localparam int MODE_SYS  = 2;
  localparam logic [2:0] MODE_RST = 3'h0;

  localparam int ATTR_W     = 7;
  localparam int ATTR_VALID = 0;
  localparam int ATTR_RO    = 1;
  localparam int ATTR_SYS   = 2;
  localparam int ATTR_EXEC  = 3;
  localparam int ATTR_WARN  = 4;
  localparam int ATTR_CHG   = 5;
  localparam int ATTR_REF   = 6;
  localparam logic [6:0] ATTR_RST = 7'h00;

  localparam int ST_W     = 3;
  localparam int ST_VIOL  = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_WARN  = 2;
  localparam logic [2:0] ST_RST = 3'h0;

  localparam int FI_W     = 4;
  localparam int FI_WRITE = 0;
  localparam int FI_SYS   = 1;
  localparam int FI_FETCH = 2;
  localparam int FI_FAULT = 3;
endpackage

// ==== verilog/paged_xlat_unit.sv ====
// paged address translation unit: 64-entry associative page table,
// protection checks, usage flags, fault capture and trap request.
// assumes all inputs synchronous to CLK_I; one request per cycle at most.
`timescale 1ns/1ps

module paged_xlat_unit (
  input  wire logic                         CLK_I,
  input  wire logic                         SRST_I,
  input  wire logic                         CS_I,
  input  wire logic [xlat_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [xlat_pkg::DATA_W-1:0]  WDATA_I,
  input  wire logic                         WR_I,
  input  wire logic                         RD_I,
  output logic      [xlat_pkg::DATA_W-1:0]  RDATA_O,
  input  wire logic                         MEM_REQ_I,
  input  wire logic [xlat_pkg::SEG_W-1:0]   SEG_I,
  input  wire logic [xlat_pkg::OFF_W-1:0]   OFF_I,
  input  wire logic                         WRITE_I,
  input  wire logic                         SYS_I,
  input  wire logic                         FETCH_I,
  output logic      [xlat_pkg::PADDR_W-1:0] PADDR_O,
  output logic                              PADDR_VLD_O,
  output logic                              ABORT_O,
  output logic                              WARN_O,
  output logic                              IRQ_O
);
  import xlat_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state

  logic [LPN_W-1:0]   tag_q   [PAGES];
  logic [FRAME_W-1:0] frame_q [PAGES];
  logic [ATTR_W-1:0]  attr_q  [PAGES];
  logic [MODE_W-1:0]  mode_q;
  logic [IDX_W-1:0]   sel_q;
  logic [ST_W-1:0]    stat_q;
  logic [ST_W-1:0]    stat_d;
  logic [ST_W-1:0]    mask_q;
  logic [LADDR_W-1:0] faddr_q;
  logic [FI_W-1:0]    finfo_q;
  logic [PADDR_W-1:0] paddr_q;
  logic               vld_q;
  logic               abort_q;
  logic               warn_q;
  logic               irq_q;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rd_val;

  function automatic logic [LPN_W-1:0] page_num(input logic [SEG_W-1:0] seg,
                                                 input logic [OFF_W-1:0] off);
    page_num = {seg, off[OFF_W-1:PAGE_OFF_W]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // command decode: ignored unless selected and in system mode

  wire cmd_ok   = CS_I & SYS_I;
  wire wr_ok    = WR_I & cmd_ok;
  wire wr_mode  = wr_ok & (ADDR_I == REG_MODE);
  wire wr_sel   = wr_ok & (ADDR_I == REG_SEL);
  wire wr_tag   = wr_ok & (ADDR_I == REG_TAG);
  wire wr_frame = wr_ok & (ADDR_I == REG_FRAME);
  wire wr_attr  = wr_ok & (ADDR_I == REG_ATTR);
  wire wr_stat  = wr_ok & (ADDR_I == REG_STAT);
  wire wr_mask  = wr_ok & (ADDR_I == REG_MASK);
  wire rd_ok    = RD_I & cmd_ok;

  //////////////////////////////////////////////////////////////////////////
  // lookup

  // 7-bit segment and upper 5 offset bits form the logical page number
  wire [LPN_W-1:0] req_lpn = page_num(SEG_I, OFF_I);

  logic             hit;
  logic [IDX_W-1:0] hit_idx;

  // lowest index wins if software loaded duplicate tags
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = PAGES - 1; i >= 0; i--) begin
      if (attr_q[i][ATTR_VALID] && (tag_q[i] == req_lpn)) begin
        hit     = 1'b1;
        hit_idx = IDX_W'(i);
      end
    end
  end

  // translation runs only in translation mode and for this unit's space
  wire space_ok = SYS_I ? mode_q[MODE_SYS] : mode_q[MODE_NORM];
  wire responds = mode_q[MODE_XLAT] & space_ok;
  wire req      = MEM_REQ_I & responds;

  wire [ATTR_W-1:0] ha = attr_q[hit_idx];
  wire ro_bad   = ha[ATTR_RO] & WRITE_I;
  wire sys_bad  = ha[ATTR_SYS] & ~SYS_I;
  wire exec_bad = ha[ATTR_EXEC] & ~FETCH_I;
  wire viol     = hit & (ro_bad | sys_bad | exec_bad);
  wire fault    = ~hit;
  wire bad      = req & (viol | fault);
  wire good     = req & hit & ~viol;
  wire low_blk  = (OFF_I[PAGE_OFF_W-1:WARN_LSB] == '0);
  wire warn_ev  = good & WRITE_I & ha[ATTR_WARN] & low_blk;

  // frame supplies bits 23:11, offset bits 10:0 pass unchanged
  wire [PADDR_W-1:0] paddr_d = {frame_q[hit_idx], OFF_I[PAGE_OFF_W-1:0]};

  wire [ST_W-1:0] ev = {warn_ev, req & fault, req & viol};
  wire [ST_W-1:0] clr = wr_stat ? WDATA_I[ST_W-1:0] : '0;

  // set wins over a same-cycle clear
  assign stat_d = (stat_q & ~clr) | ev;

  //////////////////////////////////////////////////////////////////////////
  // descriptor table

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      for (int i = 0; i < PAGES; i++) begin
        tag_q[i]   <= '0;
        frame_q[i] <= '0;
        attr_q[i]  <= ATTR_RST;
      end
    end else begin
      if (wr_tag) begin
        tag_q[sel_q] <= WDATA_I[LPN_W-1:0];
      end
      if (wr_frame) begin
        frame_q[sel_q] <= WDATA_I[FRAME_W-1:0];
      end
      if (wr_attr) begin
        attr_q[sel_q] <= WDATA_I[ATTR_W-1:0];
      end
      // later assignments win, so hardware flag sets beat software writes
      if (good) begin
        attr_q[hit_idx][ATTR_REF] <= 1'b1;
        if (WRITE_I) begin
          attr_q[hit_idx][ATTR_CHG] <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control and status

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_q  <= MODE_RST;
      sel_q   <= '0;
      stat_q  <= ST_RST;
      mask_q  <= ST_RST;
      faddr_q <= '0;
      finfo_q <= '0;
    end else begin
      if (wr_mode) begin
        mode_q <= WDATA_I[MODE_W-1:0];
      end
      if (wr_sel) begin
        sel_q <= WDATA_I[IDX_W-1:0];
      end
      if (wr_mask) begin
        mask_q <= WDATA_I[ST_W-1:0];
      end
      stat_q <= stat_d;
      // only aborts overwrite the capture, so restart data survives warnings
      if (bad) begin
        faddr_q           <= {SEG_I, OFF_I};
        finfo_q[FI_WRITE] <= WRITE_I;
        finfo_q[FI_SYS]   <= SYS_I;
        finfo_q[FI_FETCH] <= FETCH_I;
        finfo_q[FI_FAULT] <= fault;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // translation outputs, one cycle after the request

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      paddr_q <= '0;
      vld_q   <= 1'b0;
      abort_q <= 1'b0;
      warn_q  <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      paddr_q <= good ? paddr_d : '0;
      vld_q   <= good;
      abort_q <= bad;
      warn_q  <= warn_ev;
      // a new mask reaches the trap request one cycle after its write
      irq_q   <= |(stat_d & mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register read

  always_comb begin
    rd_val = '0;
    case (ADDR_I)
      REG_MODE:  rd_val[MODE_W-1:0]  = mode_q;
      REG_SEL:   rd_val[IDX_W-1:0]   = sel_q;
      REG_TAG:   rd_val[LPN_W-1:0]   = tag_q[sel_q];
      REG_FRAME: rd_val[FRAME_W-1:0] = frame_q[sel_q];
      REG_ATTR:  rd_val[ATTR_W-1:0]  = attr_q[sel_q];
      REG_STAT:  rd_val[ST_W-1:0]    = stat_q;
      REG_MASK:  rd_val[ST_W-1:0]    = mask_q;
      REG_FADDR: rd_val[LADDR_W-1:0] = faddr_q;
      REG_FINFO: rd_val[FI_W-1:0]    = finfo_q;
      default:   rd_val = '0;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_ok ? rd_val : '0;
    end
  end

  assign RDATA_O     = rdata_q;
  assign PADDR_O     = paddr_q;
  assign PADDR_VLD_O = vld_q;
  assign ABORT_O     = abort_q;
  assign WARN_O      = warn_q;
  assign IRQ_O       = irq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I);

  // rebuilt from the raw attribute bits so a slip in the viol term is caught
  sequence s_bad_ref;
    MEM_REQ_I && responds && (!hit || (ha[ATTR_RO] && WRITE_I) || (ha[ATTR_SYS] && !SYS_I)
      || (ha[ATTR_EXEC] && !FETCH_I));
  endsequence

  sequence s_abort_seen;
    ABORT_O && !PADDR_VLD_O;
  endsequence

  sequence s_fault_ref;
    MEM_REQ_I && responds && !hit;
  endsequence

  sequence s_good_ref;
    MEM_REQ_I && responds && hit && !viol;
  endsequence

  sequence s_xlat_seen;
    PADDR_VLD_O && !ABORT_O;
  endsequence

  low_bits_pass_a: assert property (PADDR_VLD_O |-> PADDR_O[10:0] == $past(OFF_I[10:0]))
    else $error("low offset bits not passed through");

  frame_map_a: assert property (MEM_REQ_I && responds && hit && !viol
      |=> PADDR_VLD_O && PADDR_O[23:11] == $past(frame_q[hit_idx]))
    else $error("translated frame mismatch");

  no_req_quiet_a: assert property (!MEM_REQ_I |=> !PADDR_VLD_O && !ABORT_O && !WARN_O)
    else $error("output without a memory reference");

  viol_abort_a: assert property (s_bad_ref |=> s_abort_seen)
    else $error("bad reference did not abort");

  fault_abort_a: assert property (s_fault_ref |=> s_abort_seen ##0 (stat_q[ST_FAULT] && finfo_q[FI_FAULT]))
    else $error("page fault not reported");

  warn_no_abort_a: assert property (warn_ev |=> WARN_O && !ABORT_O && stat_q[2])
    else $error("write warning mishandled");

  changed_flag_a: assert property (good && WRITE_I |=> attr_q[$past(hit_idx)][5])
    else $error("changed flag not set");

  ref_flag_a: assert property (good |=> attr_q[$past(hit_idx)][6])
    else $error("referenced flag not set");

  cmd_priv_a: assert property (WR_I && !SYS_I |=> $stable(mode_q) && $stable(mask_q) && $stable(sel_q))
    else $error("register changed by non-system access");

  cmd_mode_a: assert property (!mode_q[0] |=> !PADDR_VLD_O && !ABORT_O)
    else $error("translation while in command mode");

  fault_hold_a: assert property (!bad |=> $stable(faddr_q) && $stable(finfo_q))
    else $error("fault capture changed without abort");

  space_gate_a: assert property (MEM_REQ_I && !space_ok |=> !PADDR_VLD_O && !ABORT_O)
    else $error("answered outside assigned space");

  // every taken reference gets exactly one answer, one cycle on
  one_answer_a: assert property (!(PADDR_VLD_O && ABORT_O))
    else $error("translation and abort together");

  req_answer_a: assert property (MEM_REQ_I && responds |=> PADDR_VLD_O || ABORT_O)
    else $error("taken reference left unanswered");

  good_xlat_a: assert property (s_good_ref |=> s_xlat_seen)
    else $error("good reference not translated");

  paddr_idle_a: assert property (!PADDR_VLD_O |-> PADDR_O == '0)
    else $error("physical address shown without valid");

  warn_good_a: assert property (WARN_O |-> PADDR_VLD_O && $past(WRITE_I)
      && $past(OFF_I[PAGE_OFF_W-1:WARN_LSB]) == '0)
    else $error("warning outside a low-block write");

  abort_stat_a: assert property (ABORT_O |-> stat_q[ST_VIOL] || stat_q[ST_FAULT])
    else $error("abort left no status bit");

  // the trap request matches masked status in the same cycle while the mask holds still
  irq_level_a: assert property ($stable(mask_q) |-> IRQ_O == |(stat_q & mask_q))
    else $error("trap request does not follow masked status");

  stat_sticky_a: assert property (!wr_stat |=> (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("status bit dropped without a clear");

  stat_clear_a: assert property (wr_stat && !MEM_REQ_I
      |=> (stat_q & $past(WDATA_I[ST_W-1:0])) == '0)
    else $error("status bit survived a clear");

  capture_addr_a: assert property (bad |=> faddr_q == $past({SEG_I, OFF_I})
      && finfo_q[FI_WRITE] == $past(WRITE_I) && finfo_q[FI_FETCH] == $past(FETCH_I))
    else $error("fault capture does not match the aborted reference");

  rdata_idle_a: assert property (!$past(RD_I && CS_I && SYS_I) |-> RDATA_O == '0)
    else $error("read data outside the answer cycle");

  // register loads land at the edge that takes the strobe
  mode_load_a: assert property (WR_I && CS_I && SYS_I && ADDR_I == REG_MODE
      |=> mode_q == $past(WDATA_I[MODE_W-1:0]))
    else $error("mode write lost");

  sel_load_a: assert property (wr_sel |=> sel_q == $past(WDATA_I[IDX_W-1:0]))
    else $error("select write lost");

  mask_load_a: assert property (wr_mask |=> mask_q == $past(WDATA_I[ST_W-1:0]))
    else $error("mask write lost");

  tag_load_a: assert property (wr_tag |=> tag_q[$past(sel_q)] == $past(WDATA_I[LPN_W-1:0]))
    else $error("tag write lost");

  frame_load_a: assert property (wr_frame |=> frame_q[$past(sel_q)] == $past(WDATA_I[FRAME_W-1:0]))
    else $error("frame write lost");

  attr_load_a: assert property (wr_attr && !good
      |=> attr_q[$past(sel_q)] == $past(WDATA_I[ATTR_W-1:0]))
    else $error("attribute write lost");

endmodule

// ==== tb/cpu_model.sv ====
// processor-side model: register commands and memory references
// assumes the unit samples every input on the rising edge of clk_i
`timescale 1ns/1ps
module cpu_model (
  input  wire logic                        clk_i,
  input  wire logic [xlat_pkg::DATA_W-1:0] rdata_i,
  output logic                             cs_o,
  output logic      [xlat_pkg::ADDR_W-1:0] addr_o,
  output logic      [xlat_pkg::DATA_W-1:0] wdata_o,
  output logic                             wr_o,
  output logic                             rd_o,
  output logic                             mreq_o,
  output logic      [xlat_pkg::SEG_W-1:0]  seg_o,
  output logic      [xlat_pkg::OFF_W-1:0]  off_o,
  output logic                             write_o,
  output logic                             sys_o,
  output logic                             fetch_o
);
  initial begin
    {cs_o, addr_o, wdata_o, wr_o, rd_o, mreq_o, seg_o, off_o, write_o, sys_o, fetch_o} <= '0;
  end
  //////////////////////////////////////////////////////////////////////
  // s low is only used where a refused command is wanted
  task automatic cmd(input logic w, input logic [5:0] a, input logic [31:0] d, input logic s,
                     output logic [31:0] q);
    @(posedge clk_i);
    cs_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= !w;
    sys_o   <= s;
    @(posedge clk_i);
    cs_o    <= 1'b0;
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
    #1;
    q = rdata_i;
  endtask
  // only memory references raise the request; I/O never does
  task automatic mem_ref(input logic [6:0] sg, input logic [15:0] of, input logic w, s, f);
    @(posedge clk_i);
    mreq_o  <= 1'b1;
    seg_o   <= sg;
    off_o   <= of;
    write_o <= w;
    sys_o   <= s;
    fetch_o <= f;
    @(posedge clk_i);
    mreq_o  <= 1'b0;
    seg_o   <= ~sg;
    off_o   <= ~of;
    #1;
  endtask
endmodule

// ==== tb/tb_paged_xlat_unit.sv ====
// self-checking bench for the translation unit
// assumes cpu_model drives every input of the unit except clock and reset
`timescale 1ns/1ps
module tb_paged_xlat_unit;
  import xlat_pkg::*;
  // wsf is write, system, fetch; aw is abort, warn
  typedef struct packed {logic [6:0] seg; logic [15:0] off; logic [2:0] wsf;
                         logic [12:0] frame; logic [1:0] aw;} row_type;
  typedef struct packed {logic [5:0] idx; logic [11:0] tag; logic [12:0] frame; logic [6:0] attr;} page_type;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cs, wr, rd, mreq, write, sys, fetch, vld, abort, warn, irq;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [6:0]  seg;
  logic [15:0] off;
  logic [23:0] paddr;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  page_type pages [6] = '{'{6'h00, 12'h0A2, 13'h1ABC, 7'h01}, '{6'h01, 12'h200, 13'h0003, 7'h03},
    '{6'h02, 12'hFFF, 13'h1FFF, 7'h05}, '{6'h03, 12'h441, 13'h0100, 7'h09},
    '{6'h04, 12'h663, 13'h0800, 7'h11}, '{6'h3F, 12'h884, 13'h0000, 7'h00}};
  // a read-only write, a normal-mode system page and a data fetch of an execute page abort
  row_type rows [11] = '{'{7'h05, 16'h17FF, 3'b010, 13'h1ABC, 2'b00},
    '{7'h10, 16'h0123, 3'b110, 13'h0003, 2'b10}, '{7'h10, 16'h0123, 3'b000, 13'h0003, 2'b00},
    '{7'h7F, 16'hFFFF, 3'b000, 13'h1FFF, 2'b10}, '{7'h7F, 16'hFFFF, 3'b010, 13'h1FFF, 2'b00},
    '{7'h22, 16'h0800, 3'b010, 13'h0100, 2'b10}, '{7'h22, 16'h0FFE, 3'b011, 13'h0100, 2'b00},
    '{7'h33, 16'h187F, 3'b110, 13'h0800, 2'b01}, '{7'h33, 16'h1880, 3'b110, 13'h0800, 2'b00},
    '{7'h33, 16'h1800, 3'b010, 13'h0800, 2'b00}, '{7'h44, 16'h2010, 3'b010, 13'h0000, 2'b10}};

  always #5 clk = ~clk;

  paged_xlat_unit i_paged_xlat_unit (.CLK_I(clk), .SRST_I(srst), .CS_I(cs), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MEM_REQ_I(mreq), .SEG_I(seg), .OFF_I(off), .WRITE_I(write),
    .SYS_I(sys), .FETCH_I(fetch), .PADDR_O(paddr), .PADDR_VLD_O(vld), .ABORT_O(abort), .WARN_O(warn),
    .IRQ_O(irq));
  cpu_model i_cpu_model (.clk_i(clk), .rdata_i(rdata), .cs_o(cs), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .mreq_o(mreq), .seg_o(seg), .off_o(off), .write_o(write), .sys_o(sys),
    .fetch_o(fetch));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    i_cpu_model.cmd(1'b1, a, d, 1'b1, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    i_cpu_model.cmd(1'b0, a, 32'h0, 1'b1, q);
    chk(q, e);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // the whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({4'h0, paddr, vld, abort, warn, irq}, 32'h0);
    rd_chk(REG_MODE, 32'h0);
    foreach (pages[i]) begin
      wr_reg(REG_SEL, {26'h0, pages[i].idx});
      wr_reg(REG_TAG, {20'h0, pages[i].tag});
      wr_reg(REG_FRAME, {19'h0, pages[i].frame});
      wr_reg(REG_ATTR, {25'h0, pages[i].attr});
    end
    wr_reg(REG_MODE, 32'h7);
    foreach (rows[i]) begin
      i_cpu_model.mem_ref(rows[i].seg, rows[i].off, rows[i].wsf[2], rows[i].wsf[1], rows[i].wsf[0]);
      chk({29'h0, vld, abort, warn}, {29'h0, !rows[i].aw[1], rows[i].aw});
      chk({8'h0, paddr}, rows[i].aw[1] ? 32'h0 : {8'h0, rows[i].frame, rows[i].off[10:0]});
    end
    $display("table test done");
    chk({31'h0, irq}, 32'h0);
    rd_chk(REG_STAT, 32'h7);
    wr_reg(REG_MASK, 32'h2);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    wr_reg(REG_STAT, 32'h2);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd_chk(REG_STAT, 32'h5);
    rd_chk(REG_FADDR, 32'h00442010);
    rd_chk(REG_FINFO, 32'hA);
    wr_reg(REG_SEL, 32'h4);
    rd_chk(REG_ATTR, 32'h71);
    wr_reg(REG_SEL, 32'h1);
    rd_chk(REG_ATTR, 32'h43);
    wr_reg(REG_SEL, 32'h3F);
    rd_chk(REG_TAG, 32'h884);
    $display("status test done");
    i_cpu_model.cmd(1'b1, REG_MODE, 32'h0, 1'b0, q);
    rd_chk(REG_MODE, 32'h7);
    i_cpu_model.cmd(1'b0, REG_MODE, 32'h0, 1'b0, q);
    chk(q, 32'h0);
    rd_chk(6'h3C, 32'h0);
    wr_reg(REG_MODE, 32'h3);
    i_cpu_model.mem_ref(7'h05, 16'h17FF, 1'b0, 1'b1, 1'b0);
    chk({29'h0, vld, abort, warn}, 32'h0);
    i_cpu_model.mem_ref(7'h05, 16'h17FF, 1'b0, 1'b0, 1'b0);
    chk({8'h0, paddr}, 32'h00D5E7FF);
    wr_reg(REG_MODE, 32'h6);
    i_cpu_model.mem_ref(7'h05, 16'h17FF, 1'b0, 1'b1, 1'b0);
    chk({29'h0, vld, abort, warn}, 32'h0);
    $display("mode test done");
    wr_reg(REG_MASK, 32'h5);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({31'h0, irq}, 32'h0);
    rd_chk(REG_MODE, 32'h0);
    rd_chk(REG_STAT, 32'h0);
    $display("reset test done");
    results();
  end
endmodule
